/* design/fcs_synth.sv */
// Summary of operation
// - Up to four synthesizers, each with serial and general clock outputs.
// - One feedback multiplier per synthesizer, integer 1 through 32.
// - Each output port has its own independent post-scale counter.
// - Two regional/serial dividers and one global divider, each 1 to 32.
// - Divider of 1 toggles the port every cycle, half the oscillator rate, same as a divider of 2.
// - Only one serializer data rate per synthesizer.
// - Phase shift per port or all ports, step from oscillator period.
// - No dedicated clock pins; global/regional outputs may drive any I/O.
// - Lock output, enable input, asynchronous reset input provided; loop_reset here is sampled and only acts at the next rising clk edge.
// - Enable low silences outputs and drops lock; high relocks.
// - Reset high clears lock counters, reloads port counters from their phase taps, silences outputs, drops lock; then relocks.
// - Lock means stable in-phase output; may toggle, user gates it.
`timescale 1ns/100ps
`default_nettype none
module fcs_synth
	import fcs_pkg::*;
#(
	parameter int LOCK_CYCLES = int'(FCS_LOCK_CYCLES)
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Loop control
	input wire logic loop_enable,
	input wire logic loop_reset,
	// Configuration
	input wire logic [fcs_pkg::FCS_FACT_W-1:0] mult_factor,
	input wire logic [fcs_pkg::FCS_FACT_W-1:0] regional_div0,
	input wire logic [fcs_pkg::FCS_FACT_W-1:0] regional_div1,
	input wire logic [fcs_pkg::FCS_FACT_W-1:0] global_port_divider,
	input wire logic [fcs_pkg::FCS_TAP_W-1:0] phase_tap0,
	input wire logic [fcs_pkg::FCS_TAP_W-1:0] phase_tap1,
	input wire logic [fcs_pkg::FCS_TAP_W-1:0] phase_tap2,
	input wire logic phase_all,
	// Status and clocks
	output logic locked,
	output logic config_error,
	output logic [fcs_pkg::FCS_NUM_PORTS-1:0] port_clk
);
	import fcs_pkg::*;

	// One instance is one synthesizer; a device carries up to FCS_NUM_SYNTH of them
	localparam int NP = FCS_NUM_PORTS;
	localparam logic [7:0] LOCK_N = 8'(LOCK_CYCLES);

	fcs_state_t state_q;
	logic [7:0] lock_cnt_q;
	logic [FCS_FACT_W-1:0] mult_q;
	logic [FCS_FACT_W-1:0] div_q [NP];
	logic [FCS_TAP_W-1:0] tap_q [NP];
	logic [FCS_FACT_W-1:0] cnt_q [NP];
	logic [FCS_FACT_W-1:0] div_in [NP];
	logic [FCS_TAP_W-1:0] tap_in [NP];
	logic [FCS_FACT_W-1:0] fb_cnt_q;
	logic run;
	logic cfg_ok;
	logic fb_wrap;
	logic lock_done;

	function automatic logic fact_ok(input logic [FCS_FACT_W-1:0] f);
		fact_ok = (f >= FCS_FACT_MIN) && (f <= FCS_FACT_MAX);
	endfunction : fact_ok

	always_comb
	begin
		div_in[0] = regional_div0;
		div_in[1] = regional_div1;
		div_in[2] = global_port_divider;
		tap_in[0] = phase_tap0;
		tap_in[1] = phase_all ? phase_tap0 : phase_tap1;
		tap_in[2] = phase_all ? phase_tap0 : phase_tap2;
		cfg_ok = fact_ok(mult_factor) && fact_ok(regional_div0)
			&& fact_ok(regional_div1) && fact_ok(global_port_divider);
	end

	// Loop stops while disabled or reset
	assign run = loop_enable && !loop_reset;

	// Configuration is latched only while the loop is idle and valid
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mult_q <= FCS_FACT_RST;
		else if (state_q == FCS_IDLE && cfg_ok)
			mult_q <= mult_factor;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NP; i++)
				div_q[i] <= FCS_FACT_RST;
		end
		else if (state_q == FCS_IDLE && cfg_ok)
		begin
			for (int i = 0; i < NP; i++)
				div_q[i] <= div_in[i];
		end
	end

	// Taps follow tap 0 when all ports shift together
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NP; i++)
				tap_q[i] <= '0;
		end
		else if (state_q == FCS_IDLE && cfg_ok)
		begin
			for (int i = 0; i < NP; i++)
				tap_q[i] <= tap_in[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			config_error <= 1'b0;
		else
			config_error <= !cfg_ok;
	end

	// Lock acquisition: one lock step per mult_q clock cycles
	assign fb_wrap = (state_q == FCS_ACQUIRE) && (fb_cnt_q + 6'h01 >= mult_q);
	assign lock_done = fb_wrap && (lock_cnt_q + 8'h01 >= LOCK_N);

	// Disable or reset sends the loop straight back to idle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= FCS_IDLE;
		else if (!run)
			state_q <= FCS_IDLE;
		else
		begin
			unique case (state_q)
				FCS_IDLE:
				begin
					if (cfg_ok)
						state_q <= FCS_ACQUIRE;
				end
				FCS_ACQUIRE:
				begin
					if (lock_done)
						state_q <= FCS_LOCKED;
				end
				FCS_LOCKED:
					state_q <= FCS_LOCKED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fb_cnt_q <= '0;
		else if (!run || state_q != FCS_ACQUIRE)
			fb_cnt_q <= '0;
		else if (fb_wrap)
			fb_cnt_q <= '0;
		else
			fb_cnt_q <= fb_cnt_q + 6'h01;
	end

	// Counts completed feedback cycles towards lock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lock_cnt_q <= '0;
		else if (!run)
			lock_cnt_q <= '0;
		else if (fb_wrap)
			lock_cnt_q <= lock_cnt_q + 8'h01;
	end

	// Lock flag stands until enable falls or reset rises
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			locked <= 1'b0;
		else if (!run)
			locked <= 1'b0;
		else if (lock_done || state_q == FCS_LOCKED)
			locked <= 1'b1;
	end

	// Per-port post-scale counters, one per port
	for (genvar p = 0; p < NP; p++)
	begin : g_port
		// Counter restarts from its phase tap whenever the loop is not locked
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				cnt_q[p] <= '0;
			else if (state_q != FCS_LOCKED || !run)
				cnt_q[p] <= FCS_FACT_W'(tap_q[p]) % div_q[p];
			else if (div_q[p] != FCS_FACT_MIN)
				cnt_q[p] <= (cnt_q[p] + 6'h01 >= div_q[p]) ? '0 : cnt_q[p] + 6'h01;
		end

		// High while the count is below half the divider, rounded down; a divider of 1 toggles every cycle
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				port_clk[p] <= 1'b0;
			else if (state_q != FCS_LOCKED || !run)
				port_clk[p] <= 1'b0;
			else if (div_q[p] == FCS_FACT_MIN)
				port_clk[p] <= ~port_clk[p];
			else
				port_clk[p] <= cnt_q[p] < (div_q[p] >> 1);
		end
	end
endmodule : fcs_synth
`default_nettype wire

/* design/fcs_pkg.sv */
package fcs_pkg;
	localparam int FCS_NUM_SYNTH = 4;
	localparam int FCS_FACT_W = 6;
	localparam logic [5:0] FCS_FACT_MIN = 6'h01;
	localparam logic [5:0] FCS_FACT_MAX = 6'h20;
	localparam logic [5:0] FCS_FACT_RST = 6'h01;
	localparam int FCS_NUM_PORTS = 3;
	localparam int FCS_TAPS = 8;
	localparam int FCS_TAP_W = 3;
	localparam int FCS_STEP_MIN_PS = 150;
	localparam int FCS_STEP_MAX_PS = 400;
	localparam logic [7:0] FCS_LOCK_CYCLES = 8'h10;
	typedef enum logic [1:0] {FCS_IDLE, FCS_ACQUIRE, FCS_LOCKED} fcs_state_t;
endpackage : fcs_pkg

/* tb/fcs_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_chk
	import fcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic loop_enable,
	input wire logic loop_reset,
	input wire logic [5:0] mult_factor,
	input wire logic [5:0] regional_div0,
	input wire logic locked,
	input wire logic config_error,
	input wire logic [2:0] port_clk
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_off; !loop_enable [*3]; endsequence
	sequence s_held; locked [*3] ##0 regional_div0 == 6'h01; endsequence
	AST_EN: assert property (!loop_enable |=> !locked) else $error("lock kept");
	AST_RST: assert property (loop_reset |=> !locked) else $error("lock kept");
	AST_RCLR: assert property (loop_reset |=> port_clk == 3'h0) else $error("clock kept in reset");
	AST_OFF: assert property (s_off |-> port_clk == 3'h0) else $error("clock not silenced");
	AST_BIG: assert property (mult_factor > FCS_FACT_MAX |=> config_error) else $error("no error");
	AST_ZERO: assert property (mult_factor == 6'h00 |=> config_error) else $error("no error");
	AST_HOLD: assert property (config_error && !locked |=> !locked) else $error("bad lock");
	AST_STAY: assert property (locked && loop_enable && !loop_reset |=> locked) else $error("lock lost");
	AST_DIV1: assert property (s_held |-> port_clk[0] != $past(port_clk[0])) else $error("no toggle");
endmodule : fcs_chk
bind fcs_synth fcs_chk fcs_chk_i (.clk(clk), .rst_n(rst_n), .loop_enable(loop_enable), .loop_reset(loop_reset),
	.mult_factor(mult_factor), .regional_div0(regional_div0), .locked(locked), .config_error(config_error),
	.port_clk(port_clk));
`default_nettype wire

/* tb/fcs_sink.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_sink
(
	input wire logic clk,
	input wire logic locked,
	input wire logic port_in,
	output logic [7:0] period
);
	logic prev_q;
	logic [7:0] cnt_q;
	always_ff @(posedge clk)
	begin
		prev_q <= port_in;
		cnt_q <= (port_in && !prev_q) ? 8'h01 : cnt_q + 8'h01;
		if (locked && port_in && !prev_q)
			period <= cnt_q;
	end
endmodule : fcs_sink
`default_nettype wire

/* tb/fcs_synth_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_synth_bench;
	import fcs_pkg::*;
	logic clk = 0, rst_n = 0, en = 0, lr = 1, pa = 0, locked, err;
	logic [5:0] m = 1, a = 1, b = 1, c = 1;
	logic [2:0] pc, t1 = 0;
	logic [7:0] per [3];
	int num_errors = 0, total_checks = 0;
	fcs_synth #(.LOCK_CYCLES(2)) fcs_synth_i (.clk, .rst_n, .loop_enable(en), .loop_reset(lr), .mult_factor(m),
		.regional_div0(a), .regional_div1(b), .global_port_divider(c), .phase_tap0(a[2:0]), .phase_tap1(t1),
		.phase_tap2(3'h0), .phase_all(pa), .locked, .config_error(err), .port_clk(pc));
	for (genvar i = 0; i < 3; i++)
	begin : g_sink
		fcs_sink fcs_sink_i (.clk, .locked, .port_in(pc[i]), .period(per[i]));
	end
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [7:0] x, input logic [7:0] y);
		total_checks++;
		num_errors += int'(x !== y);
		if (x !== y)
			$display("MISMATCH %0t %h %h", $time, x, y);
	endtask : chk
	task automatic finish_test(input int t);
		num_errors += t;
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic run(input logic [5:0] f, x, y, z);
		int n = 0;
		@(negedge clk);
		{lr, m, a, b, c} = {1'b1, f, x, y, z};
		@(negedge clk);
		chk(8'(locked), 8'h00);
		lr = 0;
		while (locked !== 1'b1 && n < 80)
		begin
			@(negedge clk);
			n++;
		end
		repeat (99) @(negedge clk);
		if (f == 6'h00 || f > FCS_FACT_MAX)
		begin
			chk(8'(n), 8'h50);
			chk(8'(err), 8'h01);
		end
		else
		begin
			chk(8'(n), 8'(1 + 2 * f));
			chk(8'(err), 8'h00);
			chk(per[0], {2'h0, x == 6'h01 ? 6'h02 : x});
			chk(per[1], {2'h0, y == 6'h01 ? 6'h02 : y});
			chk(per[2], {2'h0, z == 6'h01 ? 6'h02 : z});
		end
	endtask : run
	initial
	begin
		repeat (3) @(negedge clk);
		{rst_n, en} = 2'b11;
		run(6'h01, 6'h01, 6'h02, 6'h20);
		run(6'h20, 6'h03, 6'h01, 6'h05);
		en = 0;
		repeat (3) @(negedge clk);
		chk(8'({locked, pc}), 8'h00);
		en = 1;
		run(6'h00, 6'h01, 6'h01, 6'h01);
		run(6'h21, 6'h01, 6'h01, 6'h01);
		run(6'h02, 6'h01, 6'h1f, 6'h02);
		{t1, pa} = 4'h5;
		run(6'h01, 6'h04, 6'h04, 6'h04);
		chk(8'({pc[1], pc[2]}), 8'({pc[0], pc[0]}));
		pa = 0;
		run(6'h01, 6'h04, 6'h04, 6'h04);
		chk(8'({pc[1], pc[2]}), 8'({~pc[0], pc[0]}));
		finish_test(0);
	end
	initial #1000000 finish_test(1);
endmodule : fcs_synth_bench
`default_nettype wire
